/* File: common/sbo_defs.vh */
// sbo_defs.vh: offsets, field positions, reset values and timing counts for
// the flash boot / option control block. assumes a 200 MHz core clock.
`ifndef SBO_DEFS_VH
`define SBO_DEFS_VH

`define SBO_ADDR_W        8
`define SBO_OFS_CFG0      8'h00
`define SBO_OFS_CFG1      8'h04
`define SBO_OFS_MB_LO     8'h08
`define SBO_OFS_MB_HI     8'h0C
`define SBO_OFS_DYN       8'h10
`define SBO_OFS_CTRL      8'h14
`define SBO_OFS_STAT      8'h18
`define SBO_OFS_CWORD     8'h1C
`define SBO_OFS_HBYTE     8'h20

// cfg0 fields
`define SBO_B_CMD32       8
`define SBO_B_ADDR32      9
`define SBO_B_SIG_OFF     11
`define SBO_B_SFDP        12
`define SBO_B_ERASE_OFF   13
`define SBO_F_CHAIN_LO    14
`define SBO_B_H_LSBF      17
`define SBO_B_H_RX_FALL   18
`define SBO_B_H_TX_FALL   19
`define SBO_B_H_CPOL      20
`define SBO_B_F_RX_FALL   23
`define SBO_B_F_TX_FALL   24
`define SBO_B_F_CPOL      25
`define SBO_F_SIG_LO      27
`define SBO_F_DIV_LO      30
`define SBO_CFG0_RST      32'h0002_2000
// cfg1 fields
`define SBO_F_PRE_LO      0
`define SBO_F_IDLE_LO     3
`define SBO_F_FWID_LO     7
`define SBO_F_HWID_LO     9
`define SBO_B_FRST_EN     11
`define SBO_B_SINGLE      12
`define SBO_B_MB_EN       13
`define SBO_B_MB_DYN      14
`define SBO_CFG1_RST      32'h0000_0000
// ctrl bits
`define SBO_B_REFRESH     0
`define SBO_B_CLR_FLAGS   1

`define SBO_START_WORD    16'hBDB3
`define SBO_SFDP_SIG      32'h5346_4450
`define SBO_CMD_RD24      8'h03
`define SBO_CMD_RD32      8'h13
`define SBO_CMD_SFDP      8'h5A
`define SBO_SFDP_DUMMY    6'd8
`define SBO_RATE_LSB      0

`define SBO_CORE_MHZ      36'd200
`define SBO_CORE_KHZ      200000
`define SBO_HALF_K(k)     ((`SBO_CORE_KHZ + 2 * (k) - 1) / (2 * (k)))
`define SBO_RATE_START_KHZ 3500
`define SBO_RATE_MAX_KHZ   180000
`define SBO_FRST_NS       10000
`define SBO_FRST_CYC      ((`SBO_FRST_NS * 200 + 999) / 1000)

`define SBO_US(t)         ((t) * `SBO_CORE_MHZ)
`define SBO_MS(t)         ((t) * `SBO_CORE_MHZ * 36'd1000)
`define SBO_TMO_TABLE     {`SBO_US(36'd100), `SBO_US(36'd500), `SBO_MS(36'd1), \
                           `SBO_MS(36'd20), `SBO_MS(36'd40), `SBO_MS(36'd50), \
                           `SBO_MS(36'd100), `SBO_MS(36'd200)}
`define SBO_IDLE_TABLE    {`SBO_MS(36'd10), `SBO_MS(36'd25), `SBO_MS(36'd50), \
                           `SBO_MS(36'd75), `SBO_MS(36'd100), `SBO_MS(36'd250), \
                           `SBO_MS(36'd500), `SBO_MS(36'd750), `SBO_MS(36'd1000), \
                           `SBO_MS(36'd5000), `SBO_MS(36'd10000), `SBO_MS(36'd25000), \
                           `SBO_MS(36'd50000), `SBO_MS(36'd100000), `SBO_MS(36'd200000)}
`endif

/* File: design/sbo_boot_ctrl.v */
// sbo_boot_ctrl: flash boot loader, target-port option logic and option registers.
// assumes a 200 MHz core clock, synchronous reset, pins synchronised here.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sbo_defs.vh"
module sbo_boot_ctrl #(
  parameter [8*36-1:0]  TMO_CYC  = `SBO_TMO_TABLE,
  parameter [15*36-1:0] IDLE_CYC = `SBO_IDLE_TABLE
) (
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        program_pin_n_i,
  input  wire        cfg_load_done_i,
  output reg  [31:0] boot_word_o,
  output reg         boot_word_valid_o,
  output reg         block_mem_erase_o,
  output wire        boot_flash_clk_o,
  output wire        boot_flash_clk_inv_o,
  output wire        boot_flash_clk_oe_o,
  output wire        boot_flash_sel_n_o,
  output wire        boot_flash_sel_n_oe_o,
  output wire        boot_flash_out_io0_o,
  output wire        boot_flash_out_io0_oe_o,
  input  wire        boot_flash_in_io1_i,
  output wire [5:0]  boot_flash_io_upper_o,
  output wire [5:0]  boot_flash_io_upper_oe_o,
  output wire        boot_flash_rst_n_o,
  output wire        boot_flash_rst_n_oe_o,
  output wire        flash_pins_released_o,
  input  wire        host_clk_i,
  input  wire        host_sel_n_i,
  input  wire        host_mosi_i,
  output wire        host_miso_o,
  output wire        host_miso_oe_o,
  output reg  [7:0]  host_byte_o,
  output reg         host_byte_valid_o,
  output wire        downstream_serial_o,
  output wire        downstream_auto_o,
  output wire [1:0]  downstream_width_o
);
  localparam [2:0] ST_FRST = 3'd0;
  localparam [2:0] ST_SIG  = 3'd1;
  localparam [2:0] ST_PRE  = 3'd2;
  localparam [2:0] ST_CTRL = 3'd3;
  localparam [2:0] ST_LOAD = 3'd4;
  localparam [2:0] ST_USER = 3'd5;
  localparam [2:0] ST_FAIL = 3'd6;

  localparam [31:0] H_START = `SBO_HALF_K(`SBO_RATE_START_KHZ);
  localparam [31:0] H_1     = `SBO_HALF_K(7100);
  localparam [31:0] H_2     = `SBO_HALF_K(14300);
  localparam [31:0] H_3     = `SBO_HALF_K(28600);
  localparam [31:0] H_4     = `SBO_HALF_K(57100);
  localparam [31:0] H_5     = `SBO_HALF_K(80000);
  localparam [31:0] H_6     = `SBO_HALF_K(100000);
  localparam [31:0] H_MAX   = `SBO_HALF_K(`SBO_RATE_MAX_KHZ);
  localparam [31:0] FRST_C  = `SBO_FRST_CYC;
  // vendor signature value is arbitrary
  localparam [31:0] VENDOR_SIG = 32'h5A5A_0001;

  reg [31:0] cfg0_q, cfg1_q, mb_lo_q, mb_hi_q, dyn_q, cword_q;
  reg [2:0]  st_q;
  reg        sig_fail_q, pre_fail_q, idle_to_q, fb_q;
  reg [2:0]  rate_q;
  reg [5:0]  half_q;
  reg        lvl_q, run_q, cs_n_q, io0_q, rx_seen_q;
  reg [47:0] tx_q;
  reg [31:0] rx_q;
  reg [5:0]  hcnt_q;
  reg [4:0]  dcnt_q;
  reg [35:0] tmo_q;
  reg [11:0] frst_q;
  reg [1:0]  div_q;
  reg        io1_s1, io1_s2, pg_s1, pg_s2, pg_p;
  reg        hc_s1, hc_s2, hc_p, hs_s1, hs_s2, hm_s1, hm_s2;
  reg [7:0]  hsh_q, htx_q;
  reg [2:0]  hbit_q;
  reg        hseen_q;
  reg [35:0] idle_q;

  // option decode
  wire       f_cmd32   = cfg0_q[`SBO_B_CMD32];
  wire       f_addr32  = cfg0_q[`SBO_B_ADDR32];
  wire       sfdp      = cfg0_q[`SBO_B_SFDP];
  wire       sig_skip  = cfg0_q[`SBO_B_SIG_OFF] & ~sfdp;
  wire       f_cpol    = cfg0_q[`SBO_B_F_CPOL];
  wire [2:0] chain     = cfg0_q[`SBO_F_CHAIN_LO+2:`SBO_F_CHAIN_LO];
  wire [2:0] sig_sel   = cfg0_q[`SBO_F_SIG_LO+2:`SBO_F_SIG_LO];
  wire [1:0] div_sel   = cfg0_q[`SBO_F_DIV_LO+1:`SBO_F_DIV_LO];
  wire [2:0] pre_sel   = cfg1_q[`SBO_F_PRE_LO+2:`SBO_F_PRE_LO];
  wire [3:0] idle_sel  = cfg1_q[`SBO_F_IDLE_LO+3:`SBO_F_IDLE_LO];
  wire [1:0] fwid      = cfg1_q[`SBO_F_FWID_LO+1:`SBO_F_FWID_LO];
  wire [1:0] hwid      = cfg1_q[`SBO_F_HWID_LO+1:`SBO_F_HWID_LO];
  wire       frst_en   = cfg1_q[`SBO_B_FRST_EN];

  // multi-boot address only when enabled; dual boot falls back to zero
  wire [31:0] mb_addr  = cfg1_q[`SBO_B_MB_DYN] ? dyn_q : mb_lo_q;
  wire [31:0] img_addr = (cfg1_q[`SBO_B_MB_EN] && !fb_q) ? mb_addr : 32'h0000_0000;
  wire [31:0] sig_addr = 32'h0000_0000;

  wire [7:0] rd_cmd  = f_cmd32 ? `SBO_CMD_RD32 : `SBO_CMD_RD24;
  wire [5:0] hdr_len = 6'd8 + (f_addr32 ? 6'd32 : 6'd24)
                       + ((st_q == ST_SIG && sfdp) ? `SBO_SFDP_DUMMY : 6'd0);
  wire [31:0] xf_addr = (st_q == ST_SIG) ? sig_addr : img_addr;
  wire [7:0]  xf_cmd  = (st_q == ST_SIG && sfdp) ? `SBO_CMD_SFDP : rd_cmd;
  wire [47:0] xf_hdr  = f_addr32 ? {xf_cmd, xf_addr, 8'h00}
                                 : {xf_cmd, xf_addr[23:0], 16'h0000};

  reg [5:0] half_tab;
  always @* begin
    case (rate_q)
      3'd0:    half_tab = H_START[5:0];
      3'd1:    half_tab = H_1[5:0];
      3'd2:    half_tab = H_2[5:0];
      3'd3:    half_tab = H_3[5:0];
      3'd4:    half_tab = H_4[5:0];
      3'd5:    half_tab = H_5[5:0];
      3'd6:    half_tab = H_6[5:0];
      default: half_tab = H_MAX[5:0];
    endcase
  end

  // engine clock: oscillator divided by div_sel + 1
  wire        eng_tick = (div_q == div_sel);
  wire [35:0] eng_step = {34'd0, div_sel} + 36'd1;
  wire [35:0] tmo_lim  = (st_q == ST_SIG) ? TMO_CYC[sig_sel*36 +: 36]
                                          : TMO_CYC[pre_sel*36 +: 36];
  wire        tmo_hit  = (tmo_q >= tmo_lim);

  // serial clock edges, judged at the pin level after polarity
  wire pin_lvl  = lvl_q ^ f_cpol;
  wire f_tick   = run_q && (half_q == 6'd0);
  wire f_rise   = f_tick && !pin_lvl;
  wire f_fall   = f_tick && pin_lvl;
  wire rx_edge  = cfg0_q[`SBO_B_F_RX_FALL] ? f_fall : f_rise;
  wire tx_edge  = cfg0_q[`SBO_B_F_TX_FALL] ? f_fall : f_rise;
  wire hdr_done = (hcnt_q == hdr_len);
  wire data_bit = rx_edge && hdr_done;
  wire [31:0] rx_n = {rx_q[30:0], io1_s2};
  wire start_x  = cs_n_q && !run_q && (st_q == ST_SIG || st_q == ST_PRE);

  wire user_mode = (st_q == ST_USER);
  wire released  = user_mode && (fwid == 2'd0);
  wire [7:0] stat = {3'b000, idle_to_q, pre_fail_q, sig_fail_q, user_mode, fb_q};

  wire refresh = (pg_p && !pg_s2)
                 || (reg_wr_i && reg_addr_i == `SBO_OFS_CTRL && reg_wdata_i[`SBO_B_REFRESH]);
  wire clr_flg = reg_wr_i && reg_addr_i == `SBO_OFS_CTRL && reg_wdata_i[`SBO_B_CLR_FLAGS];

  // pin synchronisers
  always @(posedge core_clk_i) begin
    io1_s1 <= boot_flash_in_io1_i;
    io1_s2 <= io1_s1;
    pg_s1  <= program_pin_n_i;
    pg_s2  <= pg_s1;
    hc_s1  <= host_clk_i;
    hc_s2  <= hc_s1;
    hs_s1  <= host_sel_n_i;
    hs_s2  <= hs_s1;
    hm_s1  <= host_mosi_i;
    hm_s2  <= hm_s1;
  end

  // option registers
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg0_q  <= `SBO_CFG0_RST;
      cfg1_q  <= `SBO_CFG1_RST;
      mb_lo_q <= 32'h0000_0000;
      mb_hi_q <= 32'h0000_0000;
      dyn_q   <= 32'h0000_0000;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SBO_OFS_CFG0:  cfg0_q  <= reg_wdata_i;
        `SBO_OFS_CFG1:  cfg1_q  <= {17'd0, reg_wdata_i[14:0]};
        `SBO_OFS_MB_LO: mb_lo_q <= reg_wdata_i;
        `SBO_OFS_MB_HI: mb_hi_q <= {16'd0, reg_wdata_i[15:0]};
        `SBO_OFS_DYN:   dyn_q   <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SBO_OFS_CFG0:  reg_rdata_o <= cfg0_q;
        `SBO_OFS_CFG1:  reg_rdata_o <= cfg1_q;
        `SBO_OFS_MB_LO: reg_rdata_o <= mb_lo_q;
        `SBO_OFS_MB_HI: reg_rdata_o <= mb_hi_q;
        `SBO_OFS_DYN:   reg_rdata_o <= dyn_q;
        `SBO_OFS_STAT:  reg_rdata_o <= {21'd0, rate_q, stat[4:0], st_q};
        `SBO_OFS_CWORD: reg_rdata_o <= cword_q;
        `SBO_OFS_HBYTE: reg_rdata_o <= {24'd0, host_byte_o};
        default:        reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // boot sequencer and flash shifter
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_FRST;
      sig_fail_q <= 1'b0;
      pre_fail_q <= 1'b0;
      fb_q <= 1'b0;
      rate_q <= 3'd0;
      half_q <= 6'd0;
      lvl_q <= 1'b0;
      run_q <= 1'b0;
      cs_n_q <= 1'b1;
      io0_q <= 1'b0;
      rx_seen_q <= 1'b0;
      tx_q <= 48'h0000_0000_0000;
      rx_q <= 32'h0000_0000;
      hcnt_q <= 6'd0;
      dcnt_q <= 5'd0;
      tmo_q <= 36'd0;
      frst_q <= 12'd0;
      div_q <= 2'd0;
      cword_q <= 32'h0000_0000;
      boot_word_o <= 32'h0000_0000;
      boot_word_valid_o <= 1'b0;
      block_mem_erase_o <= 1'b0;
      pg_p <= 1'b1;
    end else begin
      pg_p <= pg_s2;
      div_q <= eng_tick ? 2'd0 : div_q + 2'd1;
      boot_word_valid_o <= 1'b0;
      block_mem_erase_o <= refresh && !cfg0_q[`SBO_B_ERASE_OFF];
      // a new failure beats a clear in the same cycle
      if (clr_flg) begin
        sig_fail_q <= 1'b0;
        pre_fail_q <= 1'b0;
      end
      if (run_q) begin
        half_q <= (half_q == 6'd0) ? half_tab - 6'd1 : half_q - 6'd1;
        if (f_tick)
          lvl_q <= ~lvl_q;
      end else begin
        // park at the idle level between frames, even after a cut frame
        lvl_q <= 1'b0;
      end
      if (rx_edge) begin
        rx_q <= rx_n;
        rx_seen_q <= 1'b1;
        if (!hdr_done)
          hcnt_q <= hcnt_q + 6'd1;
      end
      // a launch edge ahead of the first sample would drop the first bit
      if (tx_edge && (rx_seen_q || rx_edge)) begin
        tx_q <= {tx_q[46:0], 1'b0};
        io0_q <= tx_q[46];
      end
      if (eng_tick)
        tmo_q <= tmo_q + eng_step;
      if (start_x) begin
        cs_n_q <= 1'b0;
        run_q <= 1'b1;
        lvl_q <= 1'b0;
        half_q <= half_tab - 6'd1;
        tx_q <= xf_hdr;
        io0_q <= xf_hdr[47];
        hcnt_q <= 6'd0;
        dcnt_q <= 5'd0;
        rx_seen_q <= 1'b0;
      end
      if (refresh) begin
        st_q <= ST_FRST;
        frst_q <= 12'd0;
        run_q <= 1'b0;
        cs_n_q <= 1'b1;
        fb_q <= 1'b0;
        rate_q <= 3'd0;
      end else begin
        case (st_q)
          ST_FRST: begin
            frst_q <= frst_q + 12'd1;
            tmo_q <= 36'd0;
            if (!frst_en || frst_q == FRST_C[11:0] - 12'd1)
              st_q <= sig_skip ? ST_PRE : ST_SIG;
          end
          ST_SIG: begin
            if (data_bit)
              dcnt_q <= dcnt_q + 5'd1;
            if (data_bit && dcnt_q == 5'd31) begin
              run_q <= 1'b0;
              cs_n_q <= 1'b1;
              // a wrong signature retries, but the timer keeps running
              if (rx_n == (sfdp ? `SBO_SFDP_SIG : VENDOR_SIG)) begin
                tmo_q <= 36'd0;
                st_q <= ST_PRE;
              end
            end else if (tmo_hit) begin
              sig_fail_q <= 1'b1;
              run_q <= 1'b0;
              cs_n_q <= 1'b1;
              st_q <= ST_FAIL;
            end
          end
          ST_PRE: begin
            if (data_bit && rx_n[15:0] == `SBO_START_WORD) begin
              st_q <= ST_CTRL;
              dcnt_q <= 5'd0;
            end else if (tmo_hit) begin
              pre_fail_q <= 1'b1;
              run_q <= 1'b0;
              cs_n_q <= 1'b1;
              tmo_q <= 36'd0;
              if (!cfg1_q[`SBO_B_SINGLE] && !fb_q && img_addr != 32'h0000_0000)
                fb_q <= 1'b1;
              else
                st_q <= ST_FAIL;
            end
          end
          ST_CTRL: begin
            if (data_bit) begin
              dcnt_q <= dcnt_q + 5'd1;
              if (dcnt_q == 5'd31) begin
                cword_q <= rx_n;
                rate_q <= rx_n[`SBO_RATE_LSB+2:`SBO_RATE_LSB];
                st_q <= ST_LOAD;
              end
            end
          end
          ST_LOAD: begin
            if (data_bit) begin
              dcnt_q <= dcnt_q + 5'd1;
              if (dcnt_q == 5'd31) begin
                boot_word_o <= rx_n;
                boot_word_valid_o <= 1'b1;
              end
            end
            if (cfg_load_done_i) begin
              run_q <= 1'b0;
              cs_n_q <= 1'b1;
              st_q <= ST_USER;
            end
          end
          ST_USER: ;
          ST_FAIL: ;
          default: st_q <= ST_FAIL;
        endcase
      end
    end
  end

  assign boot_flash_clk_o         = pin_lvl;
  assign boot_flash_clk_inv_o     = ~pin_lvl;
  assign boot_flash_clk_oe_o      = ~released;
  assign boot_flash_sel_n_o       = cs_n_q;
  assign boot_flash_sel_n_oe_o    = ~released;
  assign boot_flash_out_io0_o     = io0_q;
  assign boot_flash_out_io0_oe_o  = ~released;
  assign boot_flash_io_upper_o    = 6'h3F;
  assign boot_flash_io_upper_oe_o = (user_mode && fwid == 2'd3) ? 6'h03 : 6'h00;
  assign boot_flash_rst_n_o       = ~(st_q == ST_FRST);
  assign boot_flash_rst_n_oe_o    = frst_en;
  assign flash_pins_released_o    = released;

  // downstream chain: auto follows the host port width
  assign downstream_serial_o = (chain == 3'd1);
  assign downstream_auto_o   = (chain >= 3'd2) && (chain <= 3'd5);
  assign downstream_width_o  = hwid;

  // host port target side
  wire h_rise = hc_s2 && !hc_p;
  wire h_fall = !hc_s2 && hc_p;
  wire h_rx   = cfg0_q[`SBO_B_H_RX_FALL] ? h_fall : h_rise;
  wire h_tx   = cfg0_q[`SBO_B_H_TX_FALL] ? h_fall : h_rise;
  wire h_lsbf = cfg0_q[`SBO_B_H_LSBF];
  wire h_act  = !hs_s2;
  wire [7:0]  h_next = h_lsbf ? {hm_s2, hsh_q[7:1]} : {hsh_q[6:0], hm_s2};
  wire [35:0] idle_lim = IDLE_CYC[(idle_sel - 4'd1)*36 +: 36];
  wire        idle_exp = (idle_sel != 4'd0) && (idle_q >= idle_lim);

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hc_p <= 1'b0;
      hsh_q <= 8'h00;
      htx_q <= 8'h00;
      hbit_q <= 3'd0;
      hseen_q <= 1'b0;
      idle_q <= 36'd0;
      idle_to_q <= 1'b0;
      host_byte_o <= 8'h00;
      host_byte_valid_o <= 1'b0;
    end else begin
      host_byte_valid_o <= 1'b0;
      if (clr_flg)
        idle_to_q <= 1'b0;
      if (!h_act) begin
        // deselected: park the edge detector at the host's idle level
        hc_p <= cfg0_q[`SBO_B_H_CPOL];
        hbit_q <= 3'd0;
        hseen_q <= 1'b0;
        htx_q <= stat;
      end else begin
        hc_p <= hc_s2;
        if (h_rx) begin
          hsh_q <= h_next;
          hbit_q <= hbit_q + 3'd1;
          hseen_q <= 1'b1;
          if (hbit_q == 3'd7) begin
            host_byte_o <= h_next;
            host_byte_valid_o <= 1'b1;
          end
        end
        if (h_tx && (hseen_q || h_rx))
          htx_q <= h_lsbf ? {1'b0, htx_q[7:1]} : {htx_q[6:0], 1'b0};
      end
      // idle timer runs across a burst and restarts on any host clock edge
      if (h_rise || h_fall || idle_sel == 4'd0) begin
        idle_q <= 36'd0;
      end else if (idle_exp) begin
        idle_to_q <= 1'b1;
        hbit_q <= 3'd0;
        idle_q <= 36'd0;
      end else begin
        idle_q <= idle_q + 36'd1;
      end
    end
  end

  assign host_miso_o    = h_lsbf ? htx_q[0] : htx_q[7];
  assign host_miso_oe_o = h_act;
endmodule

/* File: verif/sbo_boot_ctrl_assertions.sv */
// sbo_boot_chk: port checks for sbo_boot_ctrl.
// assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sbo_boot_chk (
  input logic        core_clk_i,
  input logic        sys_rst_i,
  input logic [7:0]  reg_addr_i,
  input logic [31:0] reg_wdata_i,
  input logic        reg_wr_i,
  input logic        boot_word_valid_o,
  input logic        block_mem_erase_o,
  input logic        boot_flash_clk_o,
  input logic        boot_flash_clk_inv_o,
  input logic        boot_flash_clk_oe_o,
  input logic        boot_flash_sel_n_o,
  input logic        boot_flash_sel_n_oe_o,
  input logic        boot_flash_rst_n_oe_o,
  input logic        flash_pins_released_o,
  input logic        host_byte_valid_o,
  input logic        downstream_serial_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire cfg0_wr = reg_wr_i && reg_addr_i == 8'h00;
  wire cfg1_wr = reg_wr_i && reg_addr_i == 8'h04;
  a_word_spacing: assert property (boot_word_valid_o |=> !boot_word_valid_o [*8])
    else $error("boot words too close");
  a_host_pulse: assert property (host_byte_valid_o |=> !host_byte_valid_o [*8])
    else $error("host bytes too close");
  a_erase_pulse: assert property (block_mem_erase_o |=> !block_mem_erase_o)
    else $error("erase pulse too long");
  a_clk_pair: assert property (boot_flash_clk_inv_o == !boot_flash_clk_o)
    else $error("clock pair not inverse");
  a_clk_idle: assert property (boot_flash_sel_n_o [*3] |-> $stable(boot_flash_clk_o))
    else $error("clock moves while idle");
  a_release_oe: assert property (flash_pins_released_o |->
    !boot_flash_clk_oe_o && !boot_flash_sel_n_oe_o) else $error("released pins driven");
  a_rst_oe_cfg: assert property (cfg1_wr |=> boot_flash_rst_n_oe_o == $past(reg_wdata_i[11]))
    else $error("flash reset enable wrong");
  a_chain_serial: assert property (cfg0_wr |=>
    downstream_serial_o == ($past(reg_wdata_i[16:14]) == 3'h1)) else $error("chain mode wrong");
  c_word: cover property (boot_word_valid_o);
  c_erase: cover property (block_mem_erase_o);
  c_release: cover property (flash_pins_released_o);
endmodule
bind sbo_boot_ctrl sbo_boot_chk u_chk (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .boot_word_valid_o, .block_mem_erase_o, .boot_flash_clk_o, .boot_flash_clk_inv_o,
  .boot_flash_clk_oe_o, .boot_flash_sel_n_o, .boot_flash_sel_n_oe_o, .boot_flash_rst_n_oe_o,
  .flash_pins_released_o, .host_byte_valid_o, .downstream_serial_o);

/* File: verif/sbo_flash_model.sv */
// sbo_flash_model: behavioural serial flash on the boot port.
// assumes idle-low clock, read commands 8'h03 or 8'h13, image at address 0.
`timescale 1ns/1ps
module sbo_flash_model (
  input  wire  clk_i,
  input  wire  sel_n_i,
  input  wire  mosi_i,
  output logic miso_o
);
  // delayed copy gives the bit from before a launch on the same edge
  wire #1 mosi_d = mosi_i;
  logic [0:159] mem = {32'h5A5A0001, 32'hFFFFBDB3, 32'h2, 32'hC0DE1234, 32'h0};
  logic [7:0]   cmd;
  logic [31:0]  addr;
  logic         bad = 1'b0;
  int           n, per, abits = 24;
  realtime      t;
  initial miso_o = 1'b1;
  always @(negedge sel_n_i) n = 0;
  always @(posedge clk_i) if (!sel_n_i) begin
    if (n > 0) per = int'(($realtime - t) / 5.0);
    t = $realtime;
    if (n < 8) cmd = {cmd[6:0], mosi_d};
    else if (n < 8 + abits) addr = {addr[30:0], mosi_d};
    if (n == 7) begin
      abits = (cmd == 8'h13) ? 32 : 24;
      addr = 32'h0;
    end
    n++;
  end
  // undriven output toggles, so a stale bit cannot pass for data
  always @(negedge clk_i) if (!sel_n_i)
    miso_o = (n >= 8 + abits) ? bad ^ mem[(addr * 8 + n - 8 - abits) % 160] : ~miso_o;
  always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule

/* File: verif/tb_top.sv */
// tb_top: bench for sbo_boot_ctrl with a flash model on the boot port.
// assumes 200 MHz core clock; timeouts shortened through TMO_CYC.
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cfg_load_done_i = 0;
  logic host_clk_i = 0, host_sel_n_i = 1, host_mosi_i = 0;
  logic [7:0] reg_addr_i = 8'h00, host_byte_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, boot_word_o, v;
  logic [5:0] boot_flash_io_upper_o, boot_flash_io_upper_oe_o;
  logic [1:0] downstream_width_o;
  logic boot_word_valid_o, block_mem_erase_o, boot_flash_clk_o, boot_flash_clk_inv_o,
    boot_flash_clk_oe_o, boot_flash_sel_n_o, boot_flash_sel_n_oe_o, boot_flash_out_io0_o,
    boot_flash_out_io0_oe_o, boot_flash_in_io1_i, boot_flash_rst_n_o, boot_flash_rst_n_oe_o,
    flash_pins_released_o, host_miso_o, host_miso_oe_o, host_byte_valid_o,
    downstream_serial_o, downstream_auto_o;
  wire program_pin_n_i = 1'b1;
  int mismatches, checked, erases;
  wire [3:0] ev = {flash_pins_released_o, host_byte_valid_o, u_flash.n >= 4, boot_word_valid_o};
  sbo_boot_ctrl #(.TMO_CYC({8{36'h4E20}}), .IDLE_CYC({15{36'hFA0}})) u_sbo_boot_ctrl (.*);
  sbo_flash_model u_flash (.clk_i(boot_flash_clk_o), .sel_n_i(boot_flash_sel_n_o),
    .mosi_i(boot_flash_out_io0_o), .miso_o(boot_flash_in_io1_i));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (block_mem_erase_o === 1'b1) erases++;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(input int i, input int lim);
    repeat (lim) begin
      @(posedge core_clk_i);
      if (ev[i] === 1'b1) return;
    end
    mismatches++;
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1;
    @(posedge core_clk_i);
    reg_wr_i <= 0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    @(posedge core_clk_i);
    d = reg_rdata_o;
  endtask
  // slow host clock so the two-flop pin synchronisers see every edge
  task automatic hsend(input logic [7:0] b, input bit msbf);
    host_sel_n_i <= 0;
    for (int i = 0; i < 8; i++) begin
      host_mosi_i <= b[msbf ? 7 - i : i];
      repeat (8) @(posedge core_clk_i);
      host_clk_i <= 1;
      repeat (8) @(posedge core_clk_i);
      host_clk_i <= 0;
    end
    repeat (8) @(posedge core_clk_i);
    host_sel_n_i <= 1;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 0;
    rd(8'h00, v); chk("cfg0", v, 32'h0002_2000);
    rd(8'h04, v); chk("cfg1", v, 32'h0);
    rd(8'h24, v); chk("unmapped", v, 32'h0);
    wt(1, 2000); chk("start period", u_flash.per, 32'd58);
    wt(0, 20000); chk("boot word", boot_word_o, 32'hC0DE_1234);
    chk("cmd", u_flash.cmd, 8'h03); chk("abits", u_flash.abits, 32'd24);
    chk("fast period", u_flash.per, 32'd14);
    rd(8'h1C, v); chk("ctrl word", v, 32'h2);
    rd(8'h18, v); chk("rate state", {v[10:8], v[2:0]}, 6'h14);
    wr(8'h00, 32'h0002_4300);
    wr(8'h04, 32'h0000_6000);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h1);
    wt(0, 20000); chk("wide cmd", u_flash.cmd, 8'h13);
    chk("wide abits", u_flash.abits, 32'd32);
    chk("boot addr", u_flash.addr, 32'h4);
    chk("erases", erases, 32'd1);
    hsend(8'h1E, 0); chk("host lsb", host_byte_o, 8'h1E);
    wr(8'h00, 32'h0000_4300);
    hsend(8'h1E, 1); rd(8'h20, v); chk("host msb", v, 32'h1E);
    cfg_load_done_i <= 1;
    wt(3, 200); chk("oe", {boot_flash_sel_n_oe_o, boot_flash_clk_oe_o}, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF); rd(8'h04, v); chk("cfg1 rw", v, 32'h7FFF);
    chk("kept", {flash_pins_released_o, downstream_width_o, boot_flash_rst_n_oe_o}, 4'h7);
    chk("chain", {downstream_auto_o, downstream_serial_o, boot_flash_io_upper_oe_o}, 8'h43);
    u_flash.bad = 1;
    cfg_load_done_i <= 0;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3802_2000);
    wr(8'h14, 32'h1);
    repeat (300) begin
      rd(8'h18, v);
      if (v[5]) break;
      repeat (100) @(posedge core_clk_i);
    end
    chk("sig fail", {v[5], v[2:0]}, 4'hE);
    results();
  end
endmodule
